/* design/sld_pkg.sv */
// constants for the serial four digit led driver
//=============================================================
// Operation
// - serial bits shifted in on clock rise
// - strobe rise commits word to register
// - cascade output trails input by 16.5 clocks
// - cascade output changes on falling clock edges
// - cascade output always driven, never floating
// - shutdown drives all digit sinks high
// - segments that are off drive low
// - display blank after power-up
// - 32-bit digit memory holds segment settings
// - shutdown keeps digit memory and settings
// - per digit code-B decode or raw bits
// - scan one to four digits only
// - software reset and external scan clock
// - digital brightness control on multiplexed display
// - each digit written alone, others kept
// - msb first, address bits 11:8, data 7:0
package sld_pkg;
  //=============================================================
  // word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  //=============================================================
  // register addresses in the serial word
  localparam logic [3:0] ADR_NOP = 4'h0;
  localparam logic [3:0] ADR_DIG0 = 4'h1;
  localparam logic [3:0] ADR_DIG3 = 4'h4;
  localparam logic [3:0] ADR_DECODE = 4'h9;
  localparam logic [3:0] ADR_INTENS = 4'hA;
  localparam logic [3:0] ADR_LIMIT = 4'hB;
  localparam logic [3:0] ADR_SHDN = 4'hC;
  localparam logic [3:0] ADR_FEAT = 4'hE;
  //=============================================================
  // apb byte addresses: serial address times four, status above
  localparam logic [11:0] APB_STATUS = 12'h040;
  //=============================================================
  // field positions and reset values
  localparam int FEAT_RST_BIT = 0;
  localparam int FEAT_EXT_BIT = 1;
  localparam int SHDN_RUN_BIT = 0;
  localparam logic [7:0] RST_DIGIT = 8'h00;
  localparam logic [3:0] RST_DECODE = 4'h0;
  localparam logic [3:0] RST_INTENS = 4'h0;
  localparam logic [1:0] RST_LIMIT = 2'h3;
  localparam logic RST_SHDN = 1'b1;
  localparam logic [1:0] RST_FEAT = 2'h0;
  //=============================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SCAN_HZ = 800;
  localparam int PWM_STEPS = 16;
  localparam int NUM_DIGITS = 4;
  localparam int SCAN_STEP_CYC = CLK_HZ / (SCAN_HZ * NUM_DIGITS * PWM_STEPS);
endpackage

/* design/sld_top.sv */
// serial four digit led driver: link shifter, register file, scanner
`timescale 1ns/1ps
module sld_top
  import sld_pkg::*;
#(
  parameter int STEP_CYC = SCAN_STEP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  output logic cascade_out,
  input wire logic ext_scan_clk,
  output logic [3:0] digit_sink_lines,
  output logic [7:0] segment_drive_lines
);

  //=============================================================
  // link domain
  logic [15:0] shift_r;
  logic spill_r;
  logic cascade_r;

  // shift register, msb arrives first and ends at the top; the bit
  // pushed out of the top is held one more rise for the cascade
  always_ff @(posedge serial_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_r <= '0;
      spill_r <= 1'b0;
    end
    else
    begin
      shift_r <= {shift_r[14:0], serial_data_in};
      spill_r <= shift_r[15];
    end
  end

  // sixteen rises through shifter and spill flop, plus the half clock
  // to this falling edge, give the 16.5 delay
  always_ff @(negedge serial_clk or negedge presetn)
  begin
    if (!presetn)
      cascade_r <= 1'b0;
    else
      cascade_r <= spill_r;
  end

  assign cascade_out = cascade_r;

  //=============================================================
  // strobe and external clock synchronisers
  logic load_s1_r, load_s2_r, load_s3_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_s1_r <= 1'b0;
      load_s2_r <= 1'b0;
      load_s3_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      load_s1_r <= latch_strobe;
      load_s2_r <= load_s1_r;
      load_s3_r <= load_s2_r;
      ext_s1_r <= ext_scan_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // shift word is stable here: no clock rise may follow the strobe
  // sooner than the synchroniser delay of about 30 ns
  logic ser_commit;
  assign ser_commit = ce && load_s2_r && !load_s3_r;

  //=============================================================
  // apb slave, stalls one cycle while a serial word commits
  logic apb_acc, apb_wr, apb_map;
  logic [3:0] apb_reg;
  assign apb_acc = psel && penable && !ser_commit;
  assign apb_reg = paddr[5:2];
  always_comb
  begin
    apb_map = (paddr == APB_STATUS) || (paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0 &&
      ((apb_reg >= ADR_DIG0 && apb_reg <= ADR_DIG3) || apb_reg == ADR_NOP ||
       apb_reg == ADR_DECODE || apb_reg == ADR_INTENS || apb_reg == ADR_LIMIT ||
       apb_reg == ADR_SHDN || apb_reg == ADR_FEAT));
  end
  assign apb_wr = apb_acc && pwrite && apb_map && ce;
  assign pready = psel && penable && !ser_commit;
  assign pslverr = pready && !apb_map;

  // one write port: the serial word has priority, apb waits
  logic wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  always_comb
  begin
    wr_en = ser_commit || apb_wr;
    wr_addr = ser_commit ? shift_r[ADDR_MSB:ADDR_LSB] : apb_reg;
    wr_data = ser_commit ? shift_r[DATA_MSB:0] : pwdata[7:0];
  end

  //=============================================================
  // registers
  logic [7:0] digit_r [NUM_DIGITS];
  logic [3:0] decode_r;
  logic [3:0] intens_r;
  logic [1:0] limit_r;
  logic shdn_r;
  logic ext_sel_r;
  logic soft_rst_r;

  // soft reset is a one-cycle pulse after a reset write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_rst_r <= 1'b0;
    else if (ce)
      soft_rst_r <= wr_en && wr_addr == ADR_FEAT && wr_data[FEAT_RST_BIT];
  end

  // digit memory: only the addressed byte changes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_DIGITS; i++)
        digit_r[i] <= RST_DIGIT;
    end
    else if (ce)
    begin
      if (soft_rst_r)
      begin
        for (int i = 0; i < NUM_DIGITS; i++)
          digit_r[i] <= RST_DIGIT;
      end
      else if (wr_en && wr_addr >= ADR_DIG0 && wr_addr <= ADR_DIG3)
        digit_r[2'(wr_addr - ADR_DIG0)] <= wr_data;
    end
  end

  // control settings; shutdown never touches them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      decode_r <= RST_DECODE;
      intens_r <= RST_INTENS;
      limit_r <= RST_LIMIT;
      shdn_r <= RST_SHDN;
      ext_sel_r <= RST_FEAT[FEAT_EXT_BIT];
    end
    else if (ce)
    begin
      if (soft_rst_r)
      begin
        decode_r <= RST_DECODE;
        intens_r <= RST_INTENS;
        limit_r <= RST_LIMIT;
        shdn_r <= RST_SHDN;
        ext_sel_r <= RST_FEAT[FEAT_EXT_BIT];
      end
      else if (wr_en)
      begin
        unique case (wr_addr)
          ADR_DECODE: decode_r <= wr_data[3:0];
          ADR_INTENS: intens_r <= wr_data[3:0];
          ADR_LIMIT: limit_r <= wr_data[1:0];
          ADR_SHDN: shdn_r <= !wr_data[SHDN_RUN_BIT];
          ADR_FEAT: ext_sel_r <= wr_data[FEAT_EXT_BIT];
          default: ;
        endcase
      end
    end
  end

  //=============================================================
  // scan timing: internal divider or external clock rising edge
  logic [15:0] div_r;
  logic [3:0] step_r;
  logic [1:0] idx_r;
  logic tick;
  localparam logic [15:0] DIV_LAST = 16'(STEP_CYC - 1);
  assign tick = ext_sel_r ? (ext_s2_r && !ext_s3_r) : (div_r == DIV_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= '0;
    else if (ce)
      div_r <= (tick || ext_sel_r) ? 16'h0000 : div_r + 16'h0001;
  end

  // brightness steps inside each slot, digits rotate per slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_r <= '0;
      idx_r <= '0;
    end
    else if (ce && tick)
    begin
      step_r <= step_r + 4'h1;
      if (step_r == 4'hF)
        idx_r <= (idx_r >= limit_r) ? 2'h0 : idx_r + 2'h1;
    end
  end

  //=============================================================
  // code-B decoder: a..g in bits 6..0, point from data bit 7
  function automatic logic [6:0] sld_codeb(input logic [3:0] v);
    unique case (v)
      4'h0: sld_codeb = 7'h7E;
      4'h1: sld_codeb = 7'h30;
      4'h2: sld_codeb = 7'h6D;
      4'h3: sld_codeb = 7'h79;
      4'h4: sld_codeb = 7'h33;
      4'h5: sld_codeb = 7'h5B;
      4'h6: sld_codeb = 7'h5F;
      4'h7: sld_codeb = 7'h70;
      4'h8: sld_codeb = 7'h7F;
      4'h9: sld_codeb = 7'h7B;
      4'hA: sld_codeb = 7'h01;
      4'hB: sld_codeb = 7'h4F;
      4'hC: sld_codeb = 7'h37;
      4'hD: sld_codeb = 7'h0E;
      4'hE: sld_codeb = 7'h67;
      4'hF: sld_codeb = 7'h00;
    endcase
  endfunction

  logic [7:0] raw;
  logic [7:0] pattern;
  logic lit;
  always_comb
  begin
    raw = digit_r[idx_r];
    pattern = decode_r[idx_r] ? {raw[7], sld_codeb(raw[3:0])} : raw;
    lit = !shdn_r && (step_r <= intens_r) && (idx_r <= limit_r);
  end

  //=============================================================
  // pin drivers, registered; sinks are active low
  logic [3:0] sink_r;
  logic [7:0] seg_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sink_r <= 4'hF;
      seg_r <= 8'h00;
    end
    else if (ce)
    begin
      sink_r <= shdn_r ? 4'hF : ~(4'h1 << idx_r);
      seg_r <= lit ? pattern : 8'h00;
    end
  end
  assign digit_sink_lines = sink_r;
  assign segment_drive_lines = seg_r;

  //=============================================================
  // register read back
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (apb_acc && !pwrite)
    begin
      if (paddr == APB_STATUS)
        prdata = {24'h000000, step_r, idx_r, ext_sel_r, shdn_r};
      else if (apb_reg >= ADR_DIG0 && apb_reg <= ADR_DIG3)
        prdata = {24'h000000, digit_r[2'(apb_reg - ADR_DIG0)]};
      else if (apb_reg == ADR_DECODE)
        prdata = {28'h0000000, decode_r};
      else if (apb_reg == ADR_INTENS)
        prdata = {28'h0000000, intens_r};
      else if (apb_reg == ADR_LIMIT)
        prdata = {30'h00000000, limit_r};
      else if (apb_reg == ADR_SHDN)
        prdata = {31'h00000000, !shdn_r};
      else if (apb_reg == ADR_FEAT)
        prdata = {30'h00000000, ext_sel_r, 1'b0};
    end
  end

  //=============================================================
  // checks
  logic [4:0] sclk_cnt_r;
  always_ff @(posedge serial_clk or negedge presetn)
  begin
    if (!presetn)
      sclk_cnt_r <= '0;
    else if (sclk_cnt_r != 5'h12)
      sclk_cnt_r <= sclk_cnt_r + 5'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence load_edge_s;
    ce && load_s2_r && !load_s3_r && !soft_rst_r;
  endsequence

  sequence intens_word_s;
    load_edge_s ##0 (shift_r[ADDR_MSB:ADDR_LSB] == ADR_INTENS);
  endsequence

  AST_COMMIT_INTENS: assert property (intens_word_s |=> intens_r == $past(shift_r[3:0]))
    else $error("intensity word not committed");

  AST_DIG_KEEP: assert property ((load_edge_s ##0 shift_r[11:8] == ADR_DIG0)
    |=> digit_r[1] == $past(digit_r[1]) && digit_r[0] == $past(shift_r[7:0]))
    else $error("digit write disturbed another digit");

  AST_SHDN_DARK: assert property ((ce && shdn_r) |=> digit_sink_lines == 4'hF)
    else $error("digit sink active in shutdown");

  AST_SEG_OFF: assert property (digit_sink_lines == 4'hF |-> segment_drive_lines == 8'h00)
    else $error("segment driven with no digit selected");

  AST_ONE_DIGIT: assert property ($onehot0(~digit_sink_lines))
    else $error("more than one digit sink active");

  AST_SHDN_KEEP: assert property ((ce && !soft_rst_r && wr_en && wr_addr == ADR_SHDN)
    |=> $stable(intens_r) && $stable(limit_r) && $stable(decode_r) && $stable(digit_r[0]))
    else $error("settings lost across shutdown");

  AST_SOFT_RESET: assert property ((ce && soft_rst_r)
    |=> shdn_r && intens_r == RST_INTENS && limit_r == RST_LIMIT)
    else $error("software reset did not restore defaults");

  AST_STALL: assert property (ser_commit |-> !pready)
    else $error("apb accepted during serial commit");

  AST_CASCADE: assert property (@(posedge serial_clk) disable iff (!presetn)
    sclk_cnt_r == 5'h12 |-> cascade_out == $past(serial_data_in, 17))
    else $error("cascade output not delayed sixteen and a half clocks");

endmodule // sld_top

/* sim/sld_host_model.sv */
// host side model of the serial link: sends words, captures the cascade output
`timescale 1ns/1ps
module sld_host_model
(
  output logic serial_clk,
  output logic serial_data_in,
  output logic latch_strobe,
  input wire logic cascade_out
);
  // link clock stands low between frames
  initial
  begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
  end
  //=============================================================
  // one frame: msb first, 120 ns period, strobe after the last rise
  task automatic send_word(input logic [15:0] w, output logic [15:0] cap);
    #7;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_in = w[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
      #20 cap = {cap[14:0], cascade_out}; // settled after the falling edge
      #20;
    end
    serial_data_in = ~w[0]; // no pull on the line, so show the inverse
    latch_strobe = 1'b1;
    #60 latch_strobe = 1'b0; // next rise comes well over 50 ns later
  endtask
endmodule // sld_host_model

/* sim/sld_top_tb_top.sv */
// self-checking bench for the serial four digit led driver
`timescale 1ns/1ps
module sld_top_tb_top;
  import sld_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_scan_clk, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic serial_clk, serial_data_in, latch_strobe, cascade_out, e;
  logic [3:0] digit_sink_lines, cnt;
  logic [7:0] segment_drive_lines;
  logic [15:0] cap;
  int fails = 0;
  int comparisons = 0;
  int on_cnt;
  //=============================================================
  // design, partner and clocks
  sld_top #(.STEP_CYC(2)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .latch_strobe(latch_strobe),
    .cascade_out(cascade_out), .ext_scan_clk(ext_scan_clk),
    .digit_sink_lines(digit_sink_lines), .segment_drive_lines(segment_drive_lines));
  sld_host_model host (.serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .cascade_out(cascade_out));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // slow external scan clock derived off the pclk edge
  always @(posedge pclk)
  begin
    cnt <= cnt + 4'h1;
    ext_scan_clk <= cnt[3];
  end
  //=============================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer, waits for pready; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ser(input logic [15:0] w);
    host.send_word(w, cap);
    repeat (6) @(posedge pclk);
  endtask
  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //=============================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] exp [4] = '{32'h0, 32'h0, 32'h3, 32'h0};
    chk(digit_sink_lines, 4'hF);
    chk(segment_drive_lines, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'h024 + 12'(i * 4), 32'h0);
      chk(r, exp[i]);
    end
    apb(1'b1, 12'h020, 32'h55);
    chk(e, 1'b1); // unmapped place refused
  endtask
  task automatic t_serial();
    ser(16'h0105);
    ser(16'hF2A5);
    chk(cap, 16'h0105);
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h05);
    apb(1'b0, 12'h008, 32'h0);
    chk(r, 32'hA5);
  endtask
  task automatic t_scan();
    logic [31:0] s;
    ser(16'h0A0F);
    ser(16'h0B00);
    ser(16'h0C01);
    repeat (100) @(posedge pclk);
    chk(digit_sink_lines, 4'hE);
    chk(segment_drive_lines, 8'h05);
    ser(16'h0901);
    repeat (100) @(posedge pclk);
    chk(segment_drive_lines, 8'h5B);
    apb(1'b1, 12'h028, 32'h0);
    repeat (64) @(posedge pclk);
    on_cnt = 0;
    repeat (320)
    begin
      @(posedge pclk);
      on_cnt += (segment_drive_lines != 8'h00);
    end
    chk(on_cnt, 20);
    // clock enable low must freeze the scan position and step
    ce <= 1'b0;
    apb(1'b0, APB_STATUS, 32'h0);
    s = r;
    repeat (10) @(posedge pclk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk(r, s);
    ce <= 1'b1;
  endtask
  task automatic t_shdn();
    logic [31:0] s;
    apb(1'b1, 12'h030, 32'h0);
    repeat (4) @(posedge pclk);
    chk(digit_sink_lines, 4'hF);
    apb(1'b1, 12'h030, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h05);
    apb(1'b1, 12'h038, 32'h2);
    repeat (4) @(posedge pclk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk(r[1], 1'b1);
    // external clock has a 16 cycle period: two steps in 32 cycles
    s = r;
    repeat (29) @(posedge pclk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk(4'(r[7:4] - s[7:4]), 4'h2);
    apb(1'b1, 12'h038, 32'h1);
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h02C, 32'h0);
    chk(r, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h0);
  endtask
  //=============================================================
  // main sequence and watchdog
  initial
  begin
    presetn = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    cnt = 4'h0;
    ext_scan_clk = 1'b0;
    // a real falling edge, so the idle link-domain flops reset too
    #1;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_serial();
    t_scan();
    t_shdn();
    results();
  end
  initial
  begin
    #500_000;
    fails++;
    results();
  end
endmodule // sld_top_tb_top
